// ### core/lpts_ahb.sv
// AHB-Lite slave front end: single word transfers, always OKAY.
// Assumes it is the only slave; reads add one wait state.
`timescale 1ns/1ps
`default_nettype none
module lpts_ahb
    import lpts_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic      [31:0] hrdata_out,
    // Register file access
    lpts_reg_if.bus          rif
);
    lpts_dp_t    st_q;    // Data phase state
    lpts_dp_t    st_d;
    logic [7:0]  addr_q;  // Captured address
    logic [7:0]  addr_d;
    logic [31:0] rdata_q; // Read data holding register
    logic [31:0] rdata_d;
    logic        acc;     // Address phase taken

    // ****************************************
    // Address phase decode and next state
    // ****************************************
    always_comb begin
        acc     = hsel_in & htrans_in[1] & hready_in & ce_in;
        st_d    = st_q;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        case (st_q)
            LPTS_DP_IDLE, LPTS_DP_WRITE, LPTS_DP_RDDONE: begin
                // A new address phase replaces a finishing data phase
                if (acc) begin
                    st_d   = hwrite_in ? LPTS_DP_WRITE : LPTS_DP_RDWAIT;
                    addr_d = haddr_in[7:0];
                end else if (ce_in) begin
                    st_d = LPTS_DP_IDLE;
                end
            end
            LPTS_DP_RDWAIT: begin
                // Sample after any earlier write has landed
                if (ce_in) begin
                    rdata_d = rif.rdata;
                    st_d    = LPTS_DP_RDDONE;
                end
            end
            default: st_d = LPTS_DP_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q    <= LPTS_DP_IDLE;
            addr_q  <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            st_q    <= st_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Outputs; frozen clock enable stalls bus
    // ****************************************
    assign hreadyout_out = ce_in & (st_q != LPTS_DP_RDWAIT);
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_q;
    assign rif.wr_en     = ce_in & (st_q == LPTS_DP_WRITE);
    assign rif.addr      = addr_q;
    assign rif.wdata     = hwdata_in;
endmodule
`default_nettype wire

// ### core/lpts_pkg.sv
// Constants, register map and types of the power/thermal sideband block.
// Assumes one 50 MHz clock domain and a 32-bit AHB-Lite register bus.
package lpts_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00; // Control
    localparam logic [7:0]  OFS_VREQ     = 8'h04; // Voltage request
    localparam logic [7:0]  OFS_STATUS   = 8'h08; // Live status
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c; // Sticky events, W1C
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h10; // Event enables

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          CTRL_TCC_EN  = 0;     // Thermal circuit enable
    localparam logic        TCC_EN_RST   = 1'b1;
    localparam int          VREQ_SEL_LO  = 8;     // Selector at [9:8]
    localparam logic [6:0]  VCODE_RST    = 7'h00;
    localparam logic [1:0]  VSEL_INVALID = 2'h0;
    localparam logic [1:0]  VSEL_CORE    = 2'h1;
    localparam logic [1:0]  VSEL_UNCORE  = 2'h2;
    localparam logic [1:0]  VSEL_RSVD    = 2'h3;
    localparam int          VREQ_STEP_UV = 12500; // 12.5 mV per code step
    localparam int          TRIP_TEMP_C  = 120;   // Sensor trip point
    localparam logic        REFCLK_100M  = 1'b0;  // High level reserved
    localparam logic [2:0]  PM_RESET     = 3'h0;  // Power mode: in reset
    localparam int          ST_PM_LO     = 8;     // Power mode at [10:8]
    localparam int          IRQ_TRIP     = 0;
    localparam int          IRQ_EXT_HOT  = 1;
    localparam int          IRQ_TCC      = 2;
    localparam int          IRQ_INTERNAL_ERROR_FLAG     = 3;
    localparam int          IRQ_W        = 4;
    localparam logic [3:0]  IRQ_RST      = 4'h0;
    localparam int          SYNC_W       = 7;     // Synchronised inputs
    localparam logic [2:0]  HOT_MASK_RST = 3'h0;  // Own-drive echo mask

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        LPTS_DP_IDLE,
        LPTS_DP_WRITE,
        LPTS_DP_RDWAIT,
        LPTS_DP_RDDONE
    } lpts_dp_t;

endpackage

// ### core/lpts_reg_if.sv
// Register access path between the bus slave and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lpts_reg_if;
    logic        wr_en; // One-cycle write strobe
    logic [7:0]  addr;  // Byte address of the access
    logic [31:0] wdata; // Write data
    logic [31:0] rdata; // Read data for addr
    // Bus side issues accesses
    modport bus (output wr_en, output addr, output wdata, input rdata);
    // Register side serves them
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### core/lpts_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs change slowly compared with the clock.
`timescale 1ns/1ps
`default_nettype none
module lpts_sync #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire logic         ce_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // First stage, read only by second stage
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q; // Second stage
    logic [W-1:0] sync_d;

    // ****************************************
    // Next values
    // ****************************************
    always_comb begin
        meta_d = ce_in ? async_in : meta_q;
        sync_d = ce_in ? meta_q : sync_q;
    end

    // Registers; reset to all ones so idle active-low lines read released
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### core/lpts_top.sv
// Legacy power and thermal sideband pins with AHB-Lite registers.
// Assumes sensor levels and pins are asynchronous; error and link
// reset pulses come from logic on the same clock.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lpts_top (
    // Clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic      [31:0] hrdata_out,
    // Sensors and core events
    input  wire logic        trip_sensor_in,
    input  wire logic        hot_sensor_in,
    input  wire logic        internal_error_in,
    input  wire logic        link_reset_msg_in,
    // Chipset inputs
    input  wire logic [2:0]  power_mode_in,
    input  wire logic        self_refresh_ack_n_in,
    // Power management outputs
    output logic      [6:0]  voltage_request_code_out,
    output logic      [1:0]  voltage_target_select_out,
    output logic             refclk_select_out,
    // Open-drain and two-way thermal pins
    output logic             catastrophic_trip_n_out,
    output logic             catastrophic_trip_n_oe_n_out,
    input  wire logic        hot_temp_n_in,
    output logic             hot_temp_n_out,
    output logic             hot_temp_n_oe_n_out,
    // Status to the core
    output logic             halt_exec_out,
    output logic             thermal_control_circuit_out,
    output logic             internal_error_flag_out,
    output logic             irq_out
);
    import lpts_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    lpts_reg_if rif ();                     // Bus to register path
    logic [SYNC_W-1:0] sync;               // Synchronised inputs
    logic              hot_line_s;         // Hot line, active low
    logic              trip_s;             // Trip sensor
    logic              hot_s;              // Safe-limit sensor
    logic [2:0]        pm_s;               // Power mode
    logic              sr_ack_n_s;         // Self-refresh ack
    logic              pm_reset;           // Power mode holds reset
    logic              ext_hot;            // System asserts hot line
    logic              tcc_en_q;           // Control: circuit enable
    logic              tcc_en_d;
    logic [6:0]        code_q;             // Voltage code
    logic [6:0]        code_d;
    logic [1:0]        sel_q;              // Voltage target
    logic [1:0]        sel_d;
    logic              refclk_q;           // Reference select
    logic              trip_q;             // Halted by trip
    logic              trip_d;
    logic              trip_pin_q;         // Trip pin asserted
    logic              hot_out_q;          // Driving hot line
    logic              hot_out_d;
    logic [2:0]        hot_mask_q;         // Echo of own drive
    logic [2:0]        hot_mask_d;
    logic              tcc_q;              // Circuit engaged
    logic              tcc_d;
    logic              internal_error_flag_q;             // Internal error flag
    logic              internal_error_flag_d;
    logic [IRQ_W-1:0]  ev;                 // Event pulses
    logic [IRQ_W-1:0]  ev_src;             // Event levels now
    logic [IRQ_W-1:0]  ev_src_q;           // Event levels before
    logic [IRQ_W-1:0]  ist_q;              // Sticky event bits
    logic [IRQ_W-1:0]  ist_d;
    logic [IRQ_W-1:0]  imask_q;            // Event enables
    logic [IRQ_W-1:0]  imask_d;
    logic              irq_q;              // Interrupt level
    logic              wr_vreq;            // Voltage write taken

    // Register write decode, used by every writable register
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = rif.wr_en && (rif.addr == ofs);
    endfunction

    // ****************************************
    // Bus slave and input synchronisers
    // ****************************************
    lpts_ahb u_ahb (
        .mclk_in       (mclk_in),
        .rstn_in       (rstn_in),
        .ce_in         (ce_in),
        .hsel_in       (hsel_in),
        .haddr_in      (haddr_in),
        .htrans_in     (htrans_in),
        .hwrite_in     (hwrite_in),
        .hsize_in      (hsize_in),
        .hwdata_in     (hwdata_in),
        .hready_in     (hready_in),
        .hreadyout_out (hreadyout_out),
        .hresp_out     (hresp_out),
        .hrdata_out    (hrdata_out),
        .rif           (rif)
    );

    lpts_sync #(.W(SYNC_W)) u_sync (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .async_in   ({hot_temp_n_in, ~trip_sensor_in, ~hot_sensor_in,
                      power_mode_in, self_refresh_ack_n_in}),
        .rst_val_in ('1),
        .sync_out   (sync)
    );

    // Unpack; sensors travel inverted so the all-ones reset reads cool
    always_comb begin
        hot_line_s = sync[6];
        trip_s     = ~sync[5];
        hot_s      = ~sync[4];
        pm_s       = sync[3:1];
        sr_ack_n_s = sync[0];
    end

    // ****************************************
    // Thermal and error logic
    // ****************************************
    always_comb begin
        pm_reset   = (pm_s == PM_RESET);
        // Own drive echoes back low; ignore it until the echo clears
        ext_hot    = !hot_line_s && !hot_out_q && (hot_mask_q == 3'h0);
        // Trip halts first; latched until reset power mode
        trip_d     = trip_s | (trip_q & ~pm_reset);
        hot_out_d  = hot_s;
        hot_mask_d = {hot_mask_q[1:0], hot_out_q};
        // Engaged by own sensor or held by the system's line
        tcc_d      = tcc_en_q & (hot_s | ext_hot);
        // Set wins over either clear source
        internal_error_flag_d     = internal_error_in |
                     (internal_error_flag_q & ~pm_reset & ~link_reset_msg_in);
    end

    // Thermal and error registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trip_q     <= 1'b0;
            trip_pin_q <= 1'b0;
            hot_out_q  <= 1'b0;
            hot_mask_q <= HOT_MASK_RST;
            tcc_q      <= 1'b0;
            internal_error_flag_q     <= 1'b0;
            refclk_q   <= REFCLK_100M;
        end else if (ce_in) begin
            trip_q     <= trip_d;
            trip_pin_q <= trip_q;
            hot_out_q  <= hot_out_d;
            hot_mask_q <= hot_mask_d;
            tcc_q      <= tcc_d;
            internal_error_flag_q     <= internal_error_flag_d;
            refclk_q   <= REFCLK_100M;
        end
    end

    // ****************************************
    // Control and voltage request registers
    // ****************************************
    always_comb begin
        tcc_en_d = tcc_en_q;
        code_d   = code_q;
        sel_d    = sel_q;
        // Reserved target refused, previous request kept
        wr_vreq  = wr_hit(OFS_VREQ) &&
                   (rif.wdata[VREQ_SEL_LO+:2] != VSEL_RSVD);
        if (wr_hit(OFS_CTRL)) begin
            tcc_en_d = rif.wdata[CTRL_TCC_EN];
        end
        // Code and selector move in the same cycle
        if (wr_vreq) begin
            code_d = rif.wdata[6:0];
            sel_d  = rif.wdata[VREQ_SEL_LO+:2];
        end
    end

    // Control registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tcc_en_q <= TCC_EN_RST;
            code_q   <= VCODE_RST;
            sel_q    <= VSEL_INVALID;
        end else if (ce_in) begin
            tcc_en_q <= tcc_en_d;
            code_q   <= code_d;
            sel_q    <= sel_d;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_comb begin
        ev_src              = '0;
        ev_src[IRQ_TRIP]    = trip_q;
        ev_src[IRQ_EXT_HOT] = ext_hot;
        ev_src[IRQ_TCC]     = tcc_q;
        ev_src[IRQ_INTERNAL_ERROR_FLAG]    = internal_error_flag_q;
        ev                  = ev_src & ~ev_src_q; // Rising edges
        imask_d             = imask_q;
        ist_d               = ist_q;
        if (wr_hit(OFS_IRQ_MASK)) begin
            imask_d = rif.wdata[IRQ_W-1:0];
        end
        // Write one clears; a new event in that cycle wins
        if (wr_hit(OFS_IRQ_STAT)) begin
            ist_d = ist_d & ~rif.wdata[IRQ_W-1:0];
        end
        ist_d = ist_d | ev;
    end

    // Interrupt registers; output is a registered level
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ev_src_q <= IRQ_RST;
            ist_q    <= IRQ_RST;
            imask_q  <= IRQ_RST;
            irq_q    <= 1'b0;
        end else if (ce_in) begin
            ev_src_q <= ev_src;
            ist_q    <= ist_d;
            imask_q  <= imask_d;
            irq_q    <= |(ist_d & imask_d);
        end
    end

    // ****************************************
    // Read multiplexer
    // ****************************************
    always_comb begin
        rif.rdata = 32'h0000_0000; // Unmapped reads as zero
        case (rif.addr)
            OFS_CTRL:     rif.rdata[CTRL_TCC_EN] = tcc_en_q;
            OFS_VREQ: begin
                rif.rdata[6:0]            = code_q;
                rif.rdata[VREQ_SEL_LO+:2] = sel_q;
            end
            OFS_STATUS: begin
                rif.rdata[0]           = trip_q;
                rif.rdata[1]           = hot_out_q;
                rif.rdata[2]           = ext_hot;
                rif.rdata[3]           = tcc_q;
                rif.rdata[4]           = internal_error_flag_q;
                rif.rdata[5]           = ~sr_ack_n_s;
                rif.rdata[ST_PM_LO+:3] = pm_s;
            end
            OFS_IRQ_STAT: rif.rdata[IRQ_W-1:0] = ist_q;
            OFS_IRQ_MASK: rif.rdata[IRQ_W-1:0] = imask_q;
            default:      rif.rdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Pin and status outputs
    // ****************************************
    assign voltage_request_code_out     = code_q;
    assign voltage_target_select_out    = sel_q;
    assign refclk_select_out            = refclk_q;
    assign catastrophic_trip_n_out      = 1'b0;
    assign catastrophic_trip_n_oe_n_out = ~trip_pin_q;
    assign hot_temp_n_out               = 1'b0;
    assign hot_temp_n_oe_n_out          = ~hot_out_q;
    assign halt_exec_out                = trip_q;
    assign thermal_control_circuit_out  = tcc_q;
    assign internal_error_flag_out      = internal_error_flag_q;
    assign irq_out                      = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    property p_code_write;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && wr_vreq) |=> (code_q == $past(rif.wdata[6:0]));
    endproperty
    a_code_write: assert property (p_code_write)
        else $error("voltage code not loaded from write");

    property p_sel_legal;
        @(posedge mclk_in) disable iff (!rstn_in)
        sel_q != VSEL_RSVD;
    endproperty
    a_sel_legal: assert property (p_sel_legal)
        else $error("reserved voltage target driven");

    property p_trip_order;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && trip_s && !trip_q) |=> trip_q && !trip_pin_q;
    endproperty
    a_trip_order: assert property (p_trip_order)
        else $error("trip pin did not follow halt");

    property p_hot_out;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && hot_s) |=> !hot_temp_n_oe_n_out;
    endproperty
    a_hot_out: assert property (p_hot_out)
        else $error("hot line not driven at safe limit");

    property p_tcc_gate;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && !tcc_en_q) |=> !tcc_q;
    endproperty
    a_tcc_gate: assert property (p_tcc_gate)
        else $error("thermal circuit engaged while disabled");

    property p_tcc_hold;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && tcc_en_q && ext_hot) |=> tcc_q;
    endproperty
    a_tcc_hold: assert property (p_tcc_hold)
        else $error("thermal circuit dropped while line held");

    property p_internal_error_flag_set;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && internal_error_in) |=> internal_error_flag_out;
    endproperty
    a_internal_error_flag_set: assert property (p_internal_error_flag_set)
        else $error("internal error not flagged");

    property p_internal_error_flag_clear;
        @(posedge mclk_in) disable iff (!rstn_in)
        (ce_in && internal_error_flag_q && !internal_error_in &&
         (pm_reset || link_reset_msg_in)) |=> !internal_error_flag_q;
    endproperty
    a_internal_error_flag_clear: assert property (p_internal_error_flag_clear)
        else $error("internal error not cleared by reset");

    property p_refclk;
        @(posedge mclk_in) disable iff (!rstn_in)
        refclk_select_out == REFCLK_100M;
    endproperty
    a_refclk: assert property (p_refclk)
        else $error("reference select left 100 MHz");

    property p_code_stable;
        @(posedge mclk_in) disable iff (!rstn_in)
        $changed(code_q) |-> $changed(sel_q) || $past(wr_vreq);
    endproperty
    a_code_stable: assert property (p_code_stable)
        else $error("voltage code moved outside selector update");
endmodule
`default_nettype wire

// ### tb/lpts_plat.sv
// Platform model: chipset power mode, self-refresh ack and hot line.
// Assumes the bench requests changes just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module lpts_plat (
    // Requests from the bench
    input  wire logic       mclk_in,
    input  wire logic [2:0] mode_req_in,
    input  wire logic       hot_req_in,
    input  wire logic       dev_oe_n_in,
    // Pins toward the device
    output logic      [2:0] power_mode_out,
    output logic            self_refresh_ack_n_out,
    output logic            hot_temp_n_out
);
    initial power_mode_out = 3'h7;
    // Chipset steps the mode on clock edges
    always @(posedge mclk_in) power_mode_out <= mode_req_in;
    // Memory never enters self-refresh here, so no ack
    assign self_refresh_ack_n_out = 1'b1;
    // Pulled-up line, low when either party pulls it
    assign hot_temp_n_out = ~(hot_req_in | ~dev_oe_n_in);
endmodule
`default_nettype wire

// ### tb/lpts_top_tb_top.sv
// Self-checking bench for the power/thermal sideband block.
// Assumes the platform model in lpts_plat.sv.
`timescale 1ns/1ps
`default_nettype none
module lpts_top_tb_top;
    import lpts_pkg::*;
    logic mclk_in = 0, rstn_in = 0, ce_in = 1, hsel_in = 0, hwrite_in = 0;
    logic [1:0] htrans_in = 0;
    logic [2:0] hsize_in = 3'h2, power_mode_in, mode_req = 3'h7;
    logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd, v;
    logic trip_sensor_in = 0, hot_sensor_in = 0, internal_error_in = 0;
    logic link_reset_msg_in = 0, hot_req = 0, hot_temp_n_in;
    logic self_refresh_ack_n_in, hreadyout_out, hresp_out, refclk_select_out;
    logic [6:0] voltage_request_code_out;
    logic [1:0] voltage_target_select_out;
    logic catastrophic_trip_n_out, catastrophic_trip_n_oe_n_out;
    logic hot_temp_n_out, hot_temp_n_oe_n_out, halt_exec_out, irq_out;
    logic thermal_control_circuit_out, internal_error_flag_out;
    int errors = 0, checks_done = 0, seed = 72617, regm[5];
    always #10 mclk_in = ~mclk_in;
    lpts_top i_dut (.mclk_in, .rstn_in, .ce_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
        .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out,
        .trip_sensor_in, .hot_sensor_in, .internal_error_in,
        .link_reset_msg_in, .power_mode_in, .self_refresh_ack_n_in,
        .voltage_request_code_out, .voltage_target_select_out,
        .refclk_select_out, .catastrophic_trip_n_out,
        .catastrophic_trip_n_oe_n_out, .hot_temp_n_in, .hot_temp_n_out,
        .hot_temp_n_oe_n_out, .halt_exec_out, .thermal_control_circuit_out,
        .internal_error_flag_out, .irq_out);
    lpts_plat i_plat (.mclk_in, .mode_req_in(mode_req), .hot_req_in(hot_req),
        .dev_oe_n_in(hot_temp_n_oe_n_out), .power_mode_out(power_mode_in),
        .self_refresh_ack_n_out(self_refresh_ack_n_in),
        .hot_temp_n_out(hot_temp_n_in));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checks_done++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One AHB-Lite single word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        haddr_in <= {24'h0, a};
        hwrite_in <= w;
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic rdchk(input logic [7:0] a, input int ex, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        regm = '{1, 0, 0, 0, 0};
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        mode_req <= 3'h5;
        rdchk(OFS_CTRL, regm[0], "ctrl");
        rdchk(OFS_IRQ_MASK, regm[4], "mask");
        rdchk(8'h40, 0, "unmapped");
        rdchk(OFS_STATUS, 32'h500, "status");
        chk("hresp", 0, hresp_out);
        chk("refclk", REFCLK_100M, refclk_select_out);
        // Random codes over every selector value
        for (int i = 0; i < 8; i++) begin
            v = $random(seed) & 32'h37f;
            v[9:8] = i[1:0];
            bus(1'b1, OFS_VREQ, v);
            @(posedge mclk_in);
            if (i % 4 != 3) regm[1] = v;
            chk("code", regm[1] & 32'h7f, voltage_request_code_out);
            chk("select", regm[1] >> 8, voltage_target_select_out);
        end
        rdchk(OFS_VREQ, regm[1], "vreq");
        // Internal error, interrupt, clear by link message
        bus(1'b1, OFS_IRQ_MASK, 32'h8);
        internal_error_in <= 1'b1;
        @(posedge mclk_in);
        internal_error_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("internal_error_flag", 1, internal_error_flag_out);
        chk("irq", 1, irq_out);
        rdchk(OFS_IRQ_STAT, 32'h8, "stat");
        bus(1'b1, OFS_IRQ_STAT, 32'h8);
        repeat (2) @(posedge mclk_in);
        chk("irq off", 0, irq_out);
        chk("internal_error_flag held", 1, internal_error_flag_out);
        link_reset_msg_in <= 1'b1;
        @(posedge mclk_in);
        link_reset_msg_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("internal_error_flag cleared", 0, internal_error_flag_out);
        // Catastrophic trip, released by reset mode
        trip_sensor_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk("halt", 1, halt_exec_out);
        chk("trip pin", 0, catastrophic_trip_n_oe_n_out);
        trip_sensor_in <= 1'b0;
        mode_req <= PM_RESET;
        repeat (6) @(posedge mclk_in);
        chk("trip off", 1, catastrophic_trip_n_oe_n_out);
        chk("halt off", 0, halt_exec_out);
        mode_req <= 3'h5;
        // Own sensor, then the line from outside
        hot_sensor_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk("hot pin", 0, hot_temp_n_oe_n_out);
        chk("tcc own", 1, thermal_control_circuit_out);
        hot_sensor_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        hot_req <= 1'b1;
        repeat (30) @(posedge mclk_in);
        chk("tcc ext", 1, thermal_control_circuit_out);
        hot_req <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk("tcc off", 0, thermal_control_circuit_out);
        bus(1'b1, OFS_CTRL, 32'h0);
        hot_req <= 1'b1;
        repeat (8) @(posedge mclk_in);
        chk("tcc disabled", 0, thermal_control_circuit_out);
        end_of_test();
    end
endmodule
`default_nettype wire
